// File: rtl/bidir_fifo_pkg.sv
// Shared constants for the two-queue FIFO block
package bidir_fifo_pkg;
  localparam int DATA_W = 18;
  localparam int QUEUE_DEPTH = 256;
  localparam int OFFSET_RESET = 8;
  localparam logic [7:0] REG_AE_AB = 8'h00;
  localparam logic [7:0] REG_AF_AB = 8'h04;
  localparam logic [7:0] REG_AE_BA = 8'h08;
  localparam logic [7:0] REG_AF_BA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_COUNT = 8'h14;
  localparam int COUNT_BA_LSB = 16;
  localparam logic [2:0] RES_DATA = 3'h0;
  localparam logic [2:0] RES_MODE = 3'h1;
  localparam int MODE_BYPASS_BIT = 0;
endpackage

// File: rtl/queue_if.sv
// Signals between the block and one queue store
`timescale 1ns/100ps
interface queue_if #(
  parameter int W = 18,
  parameter int CW = 9
);
  logic clr;
  logic push;
  logic pop;
  logic [W-1:0] push_data;
  logic [W-1:0] pop_data;
  logic [CW-1:0] count;
  modport owner(output clr, push, pop, push_data, input pop_data, count);
  modport store(input clr, push, pop, push_data, output pop_data, count);
endinterface

// File: rtl/pin_sampler.sv
// Two-stage synchroniser for a pin bundle with rising-edge detect at bit 0
`timescale 1ns/100ps
module pin_sampler #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [W-1:0] pins,
  output logic [W-2:0] level,
  output logic rise
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic prev;
  } sampler_t;
  sampler_t cur;
  sampler_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.stage1 = pins;
    next_cur.stage2 = cur.stage1;
    next_cur.prev = cur.stage2[0];
    if (srst) begin
      next_cur = '0;
    end
  end

  always_ff @(posedge clock) begin
    cur <= next_cur;
  end

  assign level = cur.stage2[W-1:1];
  assign rise = cur.stage2[0] & ~cur.prev;
endmodule

// File: rtl/queue_store.sv
// One direction's word store with pointers and fill count
`timescale 1ns/100ps
module queue_store #(
  parameter int W = 18,
  parameter int DEPTH = 256
) (
  input wire logic clock,
  queue_if.store q
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } store_t;
  store_t cur;
  store_t next_cur;
  logic [W-1:0] mem [DEPTH];

  // Owner never pushes when full nor pops when empty
  always_comb begin
    next_cur = cur;
    if (q.clr) begin
      next_cur = '0;
    end else begin
      if (q.push) begin
        next_cur.wr_ptr = cur.wr_ptr + 1'b1;
      end
      if (q.pop) begin
        next_cur.rd_ptr = cur.rd_ptr + 1'b1;
      end
      next_cur.count = cur.count + (AW+1)'(q.push) - (AW+1)'(q.pop);
    end
  end

  always_ff @(posedge clock) begin
    cur <= next_cur;
    if (q.push && !q.clr) begin
      mem[cur.wr_ptr] <= q.push_data;
    end
  end

  assign q.pop_data = mem[cur.rd_ptr];
  assign q.count = cur.count;
endmodule

// File: rtl/bidir_fifo_port_b.sv
// Two-queue FIFO: port pins, bypass path, status flags and register slave
`timescale 1ns/100ps
module bidir_fifo_port_b
  import bidir_fifo_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic device_reset_n,
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_direction,
  input wire logic [2:0] port_a_resource_select,
  input wire logic [DATA_W-1:0] port_a_data_in,
  output logic [DATA_W-1:0] port_a_data_out,
  output logic port_a_data_oe_n,
  input wire logic port_b_clock,
  input wire logic port_b_direction,
  input wire logic port_b_enable_n,
  input wire logic port_b_output_enable_n,
  input wire logic [DATA_W-1:0] port_b_data_in,
  output logic [DATA_W-1:0] port_b_data_out,
  output logic port_b_data_oe_n,
  output logic a_to_b_empty_n,
  output logic a_to_b_almost_empty_n,
  output logic a_to_b_almost_full_n,
  output logic a_to_b_full_n,
  output logic b_to_a_empty_n,
  output logic b_to_a_almost_empty_n,
  output logic b_to_a_almost_full_n,
  output logic b_to_a_full_n,
  output logic port_b_bypass_indicator_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int AW_PINS = DATA_W + 7;
  localparam int BW_PINS = DATA_W + 4;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [AW_PINS-2:0] a_lvl;
  logic [BW_PINS-2:0] b_lvl;
  logic a_rise;
  logic b_rise;
  logic [DATA_W-1:0] a_data;
  logic [2:0] a_res;
  logic a_dir;
  logic a_sel_n;
  logic a_rst_n;
  logic [DATA_W-1:0] b_data;
  logic b_oe_n;
  logic b_en_n;
  logic b_dir;

  pin_sampler #(.W(AW_PINS)) a_pins (
    .clock(clock),
    .srst(srst),
    .pins({port_a_data_in, port_a_resource_select, port_a_direction,
           port_a_select_n, device_reset_n, port_a_clock}),
    .level(a_lvl),
    .rise(a_rise)
  );

  pin_sampler #(.W(BW_PINS)) b_pins (
    .clock(clock),
    .srst(srst),
    .pins({port_b_data_in, port_b_output_enable_n, port_b_enable_n,
           port_b_direction, port_b_clock}),
    .level(b_lvl),
    .rise(b_rise)
  );

  assign {a_data, a_res, a_dir, a_sel_n, a_rst_n} = a_lvl;
  assign {b_data, b_oe_n, b_en_n, b_dir} = b_lvl;

  // Synchroniser outputs are zero during srst, so the pin reset reads as held
  logic rst;
  assign rst = srst | ~a_rst_n;

  // ----------------------------------------------------------------
  // Port transfer strobes
  // ----------------------------------------------------------------
  logic b_wr;
  logic b_rd;
  logic a_data_sel;
  logic a_wr;
  logic a_rd;
  logic a_mode_wr;

  assign b_wr = b_rise & ~b_en_n & ~b_dir;
  assign b_rd = b_rise & ~b_en_n & b_dir;
  assign a_data_sel = a_rise & ~a_sel_n & (a_res == RES_DATA);
  assign a_wr = a_data_sel & ~a_dir;
  assign a_rd = a_data_sel & a_dir;
  assign a_mode_wr = a_rise & ~a_sel_n & ~a_dir & (a_res == RES_MODE);

  // ----------------------------------------------------------------
  // Queues
  // ----------------------------------------------------------------
  queue_if #(.W(DATA_W), .CW(CW)) ab_q ();
  queue_if #(.W(DATA_W), .CW(CW)) ba_q ();

  queue_store #(.W(DATA_W), .DEPTH(DEPTH)) ab_store (
    .clock(clock),
    .q(ab_q)
  );

  queue_store #(.W(DATA_W), .DEPTH(DEPTH)) ba_store (
    .clock(clock),
    .q(ba_q)
  );

  // ----------------------------------------------------------------
  // Flag helpers
  // ----------------------------------------------------------------
  function automatic logic above(input logic [CW-1:0] cnt, input logic [CW-1:0] off);
    return cnt > off;
  endfunction

  function automatic logic room_ok(input logic [CW-1:0] cnt, input logic [CW-1:0] off);
    return !(cnt > (CW'(DEPTH) - off));
  endfunction

  function automatic logic [CW-1:0] merge(input logic [CW-1:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return CW'((32'(old) & ~m) | (wd & m));
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bypass;
    logic [DATA_W-1:0] ab_msg;
    logic ab_msg_v;
    logic [DATA_W-1:0] ba_msg;
    logic ba_msg_v;
    logic [DATA_W-1:0] a_out;
    logic [DATA_W-1:0] b_out;
    logic ab_empty_n;
    logic ab_ae_n;
    logic ab_af_n;
    logic ab_full_n;
    logic ba_empty_n;
    logic ba_ae_n;
    logic ba_af_n;
    logic ba_full_n;
    logic byp_n;
    logic [CW-1:0] off_ae_ab;
    logic [CW-1:0] off_af_ab;
    logic [CW-1:0] off_ae_ba;
    logic [CW-1:0] off_af_ba;
    logic bus_phase;
    logic [31:0] rdata;
  } state_t;
  state_t cur;
  state_t next_cur;

  logic ab_full;
  logic ba_full;
  assign ab_full = ab_q.count == CW'(DEPTH);
  assign ba_full = ba_q.count == CW'(DEPTH);

  always_comb begin
    next_cur = cur;
    ab_q.clr = rst;
    ba_q.clr = rst;
    ab_q.push = 1'b0;
    ab_q.pop = 1'b0;
    ba_q.push = 1'b0;
    ba_q.pop = 1'b0;
    ab_q.push_data = a_data;
    ba_q.push_data = b_data;
    if (rst) begin
      next_cur = '0;
      next_cur.ab_af_n = 1'b1;
      next_cur.ab_full_n = 1'b1;
      next_cur.ba_af_n = 1'b1;
      next_cur.ba_full_n = 1'b1;
      next_cur.byp_n = 1'b1;
      next_cur.off_ae_ab = CW'(OFFSET_RESET);
      next_cur.off_af_ab = CW'(OFFSET_RESET);
      next_cur.off_ae_ba = CW'(OFFSET_RESET);
      next_cur.off_af_ba = CW'(OFFSET_RESET);
    end else begin
      // Flags take the state as it stood before this port edge,
      // so a read clears its flag in the following port cycle
      if (b_rise) begin
        next_cur.ab_empty_n = cur.bypass ? cur.ab_msg_v : (ab_q.count != '0);
        next_cur.ab_ae_n = above(ab_q.count, cur.off_ae_ab);
        next_cur.ba_af_n = room_ok(ba_q.count, cur.off_af_ba);
        next_cur.ba_full_n = cur.bypass ? !cur.ba_msg_v : !ba_full;
        next_cur.byp_n = !cur.bypass;
      end
      if (a_rise) begin
        next_cur.ba_empty_n = cur.bypass ? cur.ba_msg_v : (ba_q.count != '0);
        next_cur.ba_ae_n = above(ba_q.count, cur.off_ae_ba);
        next_cur.ab_af_n = room_ok(ab_q.count, cur.off_af_ab);
        next_cur.ab_full_n = cur.bypass ? !cur.ab_msg_v : !ab_full;
      end
      // Port B side
      if (b_wr) begin
        if (cur.bypass) begin
          if (!cur.ba_msg_v) begin
            next_cur.ba_msg = b_data;
            next_cur.ba_msg_v = 1'b1;
          end
        end else begin
          ba_q.push = !ba_full;
        end
      end
      if (b_rd) begin
        if (cur.bypass) begin
          if (cur.ab_msg_v) begin
            next_cur.b_out = cur.ab_msg;
            next_cur.ab_msg_v = 1'b0;
          end
        end else if (ab_q.count != '0) begin
          ab_q.pop = 1'b1;
          next_cur.b_out = ab_q.pop_data;
        end
      end
      // Port A side
      if (a_wr) begin
        if (cur.bypass) begin
          if (!cur.ab_msg_v) begin
            next_cur.ab_msg = a_data;
            next_cur.ab_msg_v = 1'b1;
          end
        end else begin
          ab_q.push = !ab_full;
        end
      end
      if (a_rd) begin
        if (cur.bypass) begin
          if (cur.ba_msg_v) begin
            next_cur.a_out = cur.ba_msg;
            next_cur.ba_msg_v = 1'b0;
          end
        end else if (ba_q.count != '0) begin
          ba_q.pop = 1'b1;
          next_cur.a_out = ba_q.pop_data;
        end
      end
      if (a_mode_wr) begin
        next_cur.bypass = a_data[MODE_BYPASS_BIT];
      end
      // Register slave: one wait state, write lands at the answering edge
      if ((read || write) && !cur.bus_phase) begin
        next_cur.bus_phase = 1'b1;
        next_cur.rdata = '0;
        case (address)
          REG_AE_AB: next_cur.rdata = 32'(cur.off_ae_ab);
          REG_AF_AB: next_cur.rdata = 32'(cur.off_af_ab);
          REG_AE_BA: next_cur.rdata = 32'(cur.off_ae_ba);
          REG_AF_BA: next_cur.rdata = 32'(cur.off_af_ba);
          REG_STATUS: begin
            next_cur.rdata = 32'({cur.bypass, cur.byp_n, cur.ba_full_n, cur.ba_af_n,
                                  cur.ba_ae_n, cur.ba_empty_n, cur.ab_full_n,
                                  cur.ab_af_n, cur.ab_ae_n, cur.ab_empty_n});
          end
          REG_COUNT: begin
            next_cur.rdata = (32'(ba_q.count) << COUNT_BA_LSB) | 32'(ab_q.count);
          end
          default: next_cur.rdata = '0;
        endcase
      end else begin
        next_cur.bus_phase = 1'b0;
      end
      if (write && cur.bus_phase) begin
        case (address)
          REG_AE_AB: next_cur.off_ae_ab = merge(cur.off_ae_ab, writedata, byteenable);
          REG_AF_AB: next_cur.off_af_ab = merge(cur.off_af_ab, writedata, byteenable);
          REG_AE_BA: next_cur.off_ae_ba = merge(cur.off_ae_ba, writedata, byteenable);
          REG_AF_BA: next_cur.off_af_ba = merge(cur.off_af_ba, writedata, byteenable);
          default: next_cur.bus_phase = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    cur <= next_cur;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign port_b_data_out = cur.b_out;
  assign port_b_data_oe_n = !(b_dir && !b_oe_n);
  assign port_a_data_out = cur.a_out;
  assign port_a_data_oe_n = !(a_dir && !a_sel_n);
  assign a_to_b_empty_n = cur.ab_empty_n;
  assign a_to_b_almost_empty_n = cur.ab_ae_n;
  assign a_to_b_almost_full_n = cur.ab_af_n;
  assign a_to_b_full_n = cur.ab_full_n;
  assign b_to_a_empty_n = cur.ba_empty_n;
  assign b_to_a_almost_empty_n = cur.ba_ae_n;
  assign b_to_a_almost_full_n = cur.ba_af_n;
  assign b_to_a_full_n = cur.ba_full_n;
  assign port_b_bypass_indicator_n = cur.byp_n;
  assign readdata = cur.rdata;
  assign waitrequest = (read || write) && !cur.bus_phase;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  b_pop_gate_a: assert property (
    ab_q.pop |-> b_rise && !b_en_n && b_dir && !cur.bypass)
    else $error("A-to-B pop without a port B read edge");

  b_drive_a: assert property (
    !port_b_data_oe_n |-> $past(port_b_direction, 2) && !$past(port_b_output_enable_n, 2))
    else $error("Port B bus driven outside a read with output enable");

  empty_flag_a: assert property (
    b_rise && !cur.bypass && ab_q.count == '0 |=> !a_to_b_empty_n)
    else $error("A-to-B empty flag not low for an empty queue");

  byp_empty_a: assert property (
    b_rise && cur.bypass && cur.ab_msg_v |=> a_to_b_empty_n)
    else $error("A-to-B empty flag low while bypass message waits");

  ab_ae_a: assert property (
    b_rise |=> a_to_b_almost_empty_n == ($past(ab_q.count) > $past(cur.off_ae_ab)))
    else $error("A-to-B almost-empty flag wrong");

  ab_af_a: assert property (
    a_rise |=> a_to_b_almost_full_n
      == !($past(ab_q.count) > (CW'(DEPTH) - $past(cur.off_af_ab))))
    else $error("A-to-B almost-full flag wrong");

  full_block_a: assert property (
    ab_q.push |-> !ab_full && a_rise && !a_sel_n)
    else $error("A-to-B push while full or off edge");

  ba_full_block_a: assert property (
    ba_q.push |-> ba_q.count != CW'(DEPTH) && b_rise && !b_en_n && !b_dir)
    else $error("B-to-A push while full or off edge");

  ba_read_clear_a: assert property (
    a_rise && cur.bypass && !cur.ba_msg_v |=> !b_to_a_empty_n)
    else $error("B-to-A empty flag not low after bypass read");

  byp_flag_a: assert property (
    b_rise |=> port_b_bypass_indicator_n == !$past(cur.bypass))
    else $error("Bypass indicator does not follow mode");

  reset_flags_a: assert property (
    $fell(rst) |-> !a_to_b_empty_n && !b_to_a_empty_n && a_to_b_full_n
      && b_to_a_full_n && ab_q.count == '0 && ba_q.count == '0)
    else $error("Flags or counts wrong after reset");

  bus_wait_a: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("Register access held more than one wait state");
endmodule

// File: verif/port_hosts.sv
// Behavioural hosts for both data ports, each making its own 80 ns link clock
`timescale 1ns/100ps
module port_hosts
  import bidir_fifo_pkg::*;
(
  input wire logic clock,
  output logic port_a_clock,
  output logic port_a_select_n,
  output logic port_a_direction,
  output logic [2:0] port_a_resource_select,
  output logic [DATA_W-1:0] port_a_data_in,
  output logic port_b_clock,
  output logic port_b_direction,
  output logic port_b_enable_n,
  output logic port_b_output_enable_n,
  output logic [DATA_W-1:0] port_b_data_in
);
  initial begin
    port_a_clock = 1'h0;
    port_a_select_n = 1'h1;
    port_a_direction = 1'h1;
    port_a_resource_select = RES_DATA;
    port_a_data_in = 18'h0;
    port_b_clock = 1'h0;
    port_b_direction = 1'h1;
    port_b_enable_n = 1'h1;
    port_b_output_enable_n = 1'h1;
    port_b_data_in = 18'h0;
  end

  // Four system clocks a half period keeps 40 ns setup and hold around each link edge
  task automatic half();
    repeat (4) @(posedge clock);
  endtask

  // One port A cycle; link clock stands low between cycles
  task automatic a_xfer(input logic sel_n, input logic dir, input logic [2:0] res,
                        input logic [DATA_W-1:0] d);
    port_a_select_n <= sel_n;
    port_a_direction <= dir;
    port_a_resource_select <= res;
    // A released bus flips so that stale data never looks valid
    port_a_data_in <= (dir || sel_n) ? ~port_a_data_in : d;
    half();
    port_a_clock <= 1'h1;
    half();
    port_a_clock <= 1'h0;
  endtask

  task automatic b_xfer(input logic dir, input logic en_n, input logic oe_n,
                        input logic [DATA_W-1:0] d);
    port_b_direction <= dir;
    port_b_enable_n <= en_n;
    port_b_output_enable_n <= oe_n;
    port_b_data_in <= (dir || en_n) ? ~port_b_data_in : d;
    half();
    port_b_clock <= 1'h1;
    half();
    port_b_clock <= 1'h0;
  endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the two-queue FIFO block
`timescale 1ns/100ps
module tb_top;
  import bidir_fifo_pkg::*;
  localparam int DEPTH = 16;
  localparam logic [DATA_W-1:0] AB_WORDS [3] = '{18'h2A5A5, 18'h15A5A, 18'h3FFFF};
  logic clock, srst, device_reset_n, read, write, waitrequest;
  logic port_a_clock, port_a_select_n, port_a_direction, port_a_data_oe_n;
  logic port_b_clock, port_b_direction, port_b_enable_n, port_b_output_enable_n;
  logic port_b_data_oe_n, port_b_bypass_indicator_n;
  logic a_to_b_empty_n, a_to_b_almost_empty_n, a_to_b_almost_full_n, a_to_b_full_n;
  logic b_to_a_empty_n, b_to_a_almost_empty_n, b_to_a_almost_full_n, b_to_a_full_n;
  logic [2:0] port_a_resource_select;
  logic [DATA_W-1:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
  logic [7:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, q;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  bidir_fifo_port_b #(.DEPTH(DEPTH)) bidir_fifo_port_b_i (.clock, .srst, .device_reset_n,
    .port_a_clock, .port_a_select_n, .port_a_direction, .port_a_resource_select,
    .port_a_data_in, .port_a_data_out, .port_a_data_oe_n, .port_b_clock, .port_b_direction,
    .port_b_enable_n, .port_b_output_enable_n, .port_b_data_in, .port_b_data_out,
    .port_b_data_oe_n, .a_to_b_empty_n, .a_to_b_almost_empty_n, .a_to_b_almost_full_n,
    .a_to_b_full_n, .b_to_a_empty_n, .b_to_a_almost_empty_n, .b_to_a_almost_full_n,
    .b_to_a_full_n, .port_b_bypass_indicator_n, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest);

  port_hosts host_i (.clock, .port_a_clock, .port_a_select_n, .port_a_direction,
    .port_a_resource_select, .port_a_data_in, .port_b_clock, .port_b_direction,
    .port_b_enable_n, .port_b_output_enable_n, .port_b_data_in);

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; this ceiling only catches a hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One register access; holds the request until waitrequest is sampled low
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge clock);
    while (waitrequest !== 1'h0) @(posedge clock);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask

  // Flags and read data land three clocks after a link rising edge
  task automatic st();
    repeat (2) @(posedge clock);
  endtask

  task automatic idle_a();
    host_i.a_xfer(1'h1, 1'h1, RES_DATA, 18'h0);
  endtask

  task automatic idle_b();
    host_i.b_xfer(1'h1, 1'h1, 1'h1, 18'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({a_to_b_empty_n, a_to_b_almost_empty_n, a_to_b_almost_full_n, a_to_b_full_n,
         b_to_a_empty_n, b_to_a_almost_empty_n, b_to_a_almost_full_n, b_to_a_full_n,
         port_b_bypass_indicator_n}, 9'h067);
    for (int r = 0; r < 4; r++) begin
      av(1'h0, 8'(r * 4), 32'h0);
      chk(q, OFFSET_RESET);
    end
    av(1'h1, REG_STATUS, 32'hFFFF);
    av(1'h0, REG_STATUS, 32'h0);
    chk(q, 32'h1CC);
    av(1'h0, 8'h20, 32'h0);
    chk(q, 32'h0);
  endtask

  task automatic t_a_to_b();
    av(1'h1, REG_AE_AB, 32'h1);
    av(1'h1, REG_AF_AB, 32'hE);
    for (int i = 0; i < 3; i++) host_i.a_xfer(1'h0, 1'h0, RES_DATA, AB_WORDS[i]);
    idle_a();
    idle_b();
    st();
    chk(a_to_b_empty_n, 1);
    chk(a_to_b_almost_empty_n, 1);
    chk(a_to_b_almost_full_n, 0);
    host_i.b_xfer(1'h1, 1'h1, 1'h0, 18'h0);
    st();
    chk(port_b_data_oe_n, 0);
    av(1'h0, REG_COUNT, 32'h0);
    chk(q[8:0], 3);
    for (int i = 0; i < 3; i++) begin
      host_i.b_xfer(1'h1, 1'h0, i == 2, 18'h0);
      st();
      chk(port_b_data_out, AB_WORDS[i]);
    end
    chk(port_b_data_oe_n, 1);
    chk(a_to_b_almost_empty_n, 0);
    idle_b();
    st();
    chk(a_to_b_empty_n, 0);
    host_i.b_xfer(1'h1, 1'h0, 1'h0, 18'h0);
    st();
    chk(port_b_data_out, AB_WORDS[2]);
  endtask

  task automatic t_b_to_a();
    for (int i = 0; i <= DEPTH; i++) host_i.b_xfer(1'h0, 1'h0, 1'h1, 18'(32'h100 + i));
    idle_b();
    st();
    chk(b_to_a_full_n, 0);
    chk(b_to_a_almost_full_n, 0);
    av(1'h0, REG_COUNT, 32'h0);
    chk(q[24:16], DEPTH);
    idle_a();
    st();
    chk(b_to_a_empty_n, 1);
    chk(b_to_a_almost_empty_n, 1);
    for (int i = 0; i < DEPTH; i++) begin
      host_i.a_xfer(1'h0, 1'h1, RES_DATA, 18'h0);
      st();
      chk(port_a_data_out, 32'h100 + i);
    end
    chk(port_a_data_oe_n, 0);
    idle_a();
    st();
    chk(b_to_a_empty_n, 0);
    chk(b_to_a_almost_empty_n, 0);
    chk(port_a_data_oe_n, 1);
    idle_b();
    st();
    chk(b_to_a_full_n, 1);
    chk(b_to_a_almost_full_n, 1);
  endtask

  task automatic t_bypass();
    host_i.a_xfer(1'h0, 1'h0, RES_MODE, 18'h1);
    idle_b();
    st();
    chk(port_b_bypass_indicator_n, 0);
    host_i.a_xfer(1'h0, 1'h0, RES_DATA, 18'h2C3A5);
    idle_a();
    idle_b();
    st();
    chk(a_to_b_full_n, 0);
    chk(a_to_b_empty_n, 1);
    host_i.b_xfer(1'h1, 1'h0, 1'h0, 18'h0);
    st();
    chk(port_b_data_out, 18'h2C3A5);
    idle_b();
    idle_a();
    st();
    chk(a_to_b_empty_n, 0);
    chk(a_to_b_full_n, 1);
    host_i.b_xfer(1'h0, 1'h0, 1'h1, 18'h1D2E3);
    idle_a();
    idle_b();
    st();
    chk(b_to_a_empty_n, 1);
    chk(b_to_a_full_n, 0);
    host_i.a_xfer(1'h0, 1'h1, RES_DATA, 18'h0);
    st();
    chk(port_a_data_out, 18'h1D2E3);
    idle_a();
    st();
    chk(b_to_a_empty_n, 0);
    idle_b();
    st();
    chk(b_to_a_full_n, 1);
    host_i.a_xfer(1'h0, 1'h0, RES_MODE, 18'h0);
    idle_b();
    st();
    chk(port_b_bypass_indicator_n, 1);
  endtask

  task automatic t_pin_reset();
    host_i.a_xfer(1'h0, 1'h0, RES_DATA, 18'h3);
    idle_b();
    chk(a_to_b_empty_n, 1);
    device_reset_n <= 1'h0;
    repeat (4) @(posedge clock);
    device_reset_n <= 1'h1;
    repeat (4) @(posedge clock);
    av(1'h0, REG_COUNT, 32'h0);
    chk(q, 32'h0);
    av(1'h0, REG_AE_AB, 32'h0);
    chk(q, OFFSET_RESET);
    chk(a_to_b_empty_n, 0);
  endtask

  initial begin
    srst = 1'h1;
    device_reset_n = 1'h1;
    read = 1'h0;
    write = 1'h0;
    address = 8'h0;
    writedata = 32'h0;
    byteenable = 4'hF;
    repeat (3) @(posedge clock);
    srst <= 1'h0;
    repeat (3) @(posedge clock);
    t_reset();
    t_a_to_b();
    t_b_to_a();
    t_bypass();
    t_pin_reset();
    final_report();
  end
endmodule
